// ---- adc_cfg_pkg.sv ----
// constants, field layout and carrier types for the adc output config bank
// assumes a 16-bit register port with one-cycle read latency
package adc_cfg_pkg;
    localparam logic [3:0]  ADDR_REG2       = 4'h2;
    localparam logic [3:0]  ADDR_SER_RATE   = 4'h3;
    localparam logic [3:0]  ADDR_OFS_TEST   = 4'h4;
    localparam logic [3:0]  ADDR_CUSTOM     = 4'h5;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    // register 3 fields
    localparam int          SER_RATE_LSB    = 13;
    localparam int          GAIN_EN_BIT     = 12;
    localparam int          DLY_HI_LSB      = 9;
    localparam int          OFS_EN_BIT      = 8;
    localparam logic [15:0] SER_RATE_WMASK  = 16'hf700;
    // register 4 fields
    localparam int          AUTO_OFS_BIT    = 15;
    localparam int          START_SEL_BIT   = 14;
    localparam int          START_MAN_BIT   = 13;
    localparam int          ACC_LSB         = 9;
    localparam int          LANE_SEL_BIT    = 8;
    localparam int          PRN_HOLD_BIT    = 7;
    localparam int          PRN_LEN_BIT     = 6;
    localparam int          PRN_EN_BIT      = 5;
    localparam int          MSB_FIRST_BIT   = 4;
    localparam int          RES_LSB         = 0;
    localparam logic [15:0] OFS_TEST_WMASK  = 16'hfff3;
    // register 2 local fields
    localparam int          PAT_LSB         = 7;
    localparam int          DLY_LO_LSB      = 0;
    localparam logic [15:0] REG2_WMASK      = 16'h03bf;
    // codes
    localparam logic [2:0]  SER_12X         = 3'h0;
    localparam logic [2:0]  SER_14X         = 3'h1;
    localparam logic [2:0]  SER_16X         = 3'h4;
    localparam logic [4:0]  BITS_12         = 5'h0c;
    localparam logic [4:0]  BITS_14         = 5'h0e;
    localparam logic [4:0]  BITS_16         = 5'h10;
    localparam logic [1:0]  RES_12          = 2'h0;
    localparam logic [1:0]  RES_14          = 2'h1;
    localparam logic [2:0]  PAT_CUSTOM      = 3'h3;
    localparam logic [22:0] PRN_SEED        = 23'h7fffff;

    typedef struct packed {
        logic [4:0] bits_per_sample;
        logic       msb_first;
        logic       res_14bit;
        logic       cfg_error;
    } ser_cfg_t;

    typedef struct packed {
        logic       gain_en;
        logic       offset_en;
        logic       auto_mode;
        logic [3:0] acc_len;
        logic [7:0] trig_delay;
    } dsp_cfg_t;

    typedef struct packed {
        logic        per_lane;
        logic [2:0]  global_mode;
        logic        custom_active;
        logic [15:0] custom_word;
    } pat_cfg_t;
endpackage : adc_cfg_pkg

// ---- adc_output_config_regs.sv ----
// register bank for the adc serial output, offset removal and test patterns
// assumes a synchronous host port on clk_sys_in and pins from outside the domain
`timescale 1ns/1ps
`default_nettype none
module adc_output_config_regs
(
    // clock and reset
    input  wire logic                    clk_sys_in,
    input  wire logic                    arst_n_in,
    // register port
    input  wire logic [3:0]              addr_in,
    input  wire logic [15:0]             wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic      [15:0]             rdata_out,
    // pins and datapath
    input  wire logic                    transmit_trigger_pin_in,
    input  wire logic                    sample_tick_in,
    // decoded configuration
    output adc_cfg_pkg::ser_cfg_t        ser_cfg_out,
    output adc_cfg_pkg::dsp_cfg_t        dsp_cfg_out,
    output adc_cfg_pkg::pat_cfg_t        pat_cfg_out,
    // offset correction control
    output logic                         corr_start_out,
    output logic                         corr_busy_out,
    // pseudo-random generator
    output logic                         prn_bit_out,
    output logic      [22:0]             prn_state_out
);
    import adc_cfg_pkg::*;

    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    typedef enum logic [2:0] {
        CORR_IDLE  = 3'b001,
        CORR_DELAY = 3'b010,
        CORR_ACC   = 3'b100
    } corr_state_t;

    logic [15:0] reg2_r;
    logic [15:0] ser_rate_r;
    logic [15:0] ofs_test_r;
    logic [15:0] custom_r;
    logic [15:0] rdata_r;
    logic [2:0]  trig_sync_r;
    logic        trig_level_r;
    logic [22:0] prn_r;
    logic [22:0] prn_nxt;
    logic [7:0]  dly_cnt_r;
    logic [7:0]  dly_cnt_nxt;
    logic [15:0] acc_cnt_r;
    logic [15:0] acc_cnt_nxt;
    corr_state_t corr_r;
    corr_state_t corr_nxt;

    // decode
    wire         wr_reg2     = wr_in && (addr_in == ADDR_REG2);
    wire         wr_ser      = wr_in && (addr_in == ADDR_SER_RATE);
    wire         wr_ofs      = wr_in && (addr_in == ADDR_OFS_TEST);
    wire         wr_custom   = wr_in && (addr_in == ADDR_CUSTOM);
    wire [2:0]   ser_code    = ser_rate_r[SER_RATE_LSB +: 3];
    wire [1:0]   res_code    = ofs_test_r[RES_LSB +: 2];
    wire         auto_mode   = ofs_test_r[AUTO_OFS_BIT];
    wire         start_pin   = ofs_test_r[START_SEL_BIT];
    wire         start_man   = ofs_test_r[START_MAN_BIT];
    wire [3:0]   acc_len     = ofs_test_r[ACC_LSB +: 4];
    wire [2:0]   pat_mode    = reg2_r[PAT_LSB +: 3];
    wire [7:0]   trig_delay  = {ser_rate_r[DLY_HI_LSB +: 2], reg2_r[DLY_LO_LSB +: 6]};
    wire         prn_hold    = ofs_test_r[PRN_HOLD_BIT];
    wire         prn_short   = ofs_test_r[PRN_LEN_BIT];
    wire         prn_en      = ofs_test_r[PRN_EN_BIT];

    // trigger pin, counted once stages two and three agree
    wire         trig_rise   = (trig_sync_r[1] == trig_sync_r[2]) && trig_sync_r[2]
                               && !trig_level_r;
    wire         start_event = auto_mode && (start_pin ? trig_rise : start_man);
    // 2^acc_len samples per estimate
    wire [15:0]  acc_target  = 16'h0001 << acc_len;

    // serial format
    wire [4:0]   bits_sel    = (ser_code == SER_14X) ? BITS_14 :
                               (ser_code == SER_16X) ? BITS_16 : BITS_12;
    wire         ser_bad     = (ser_code != SER_12X) && (ser_code != SER_14X)
                               && (ser_code != SER_16X);
    wire         res_bad     = (res_code != RES_12) && (res_code != RES_14);

    // read mux
    wire [15:0]  rd_mux      = (addr_in == ADDR_REG2)     ? reg2_r     :
                               (addr_in == ADDR_SER_RATE) ? ser_rate_r :
                               (addr_in == ADDR_OFS_TEST) ? ofs_test_r :
                               (addr_in == ADDR_CUSTOM)   ? custom_r   : RST_WORD;

    // prbs feedback: x^23+x^18+1 or x^9+x^5+1
    wire         fb_long     = prn_r[22] ^ prn_r[17];
    wire         fb_short    = prn_r[8] ^ prn_r[4];

    always_comb
    begin
        if (prn_hold)
        begin
            prn_nxt = PRN_SEED;
        end
        else if (prn_en)
        begin
            if (prn_short)
            begin
                prn_nxt = {14'h0000, prn_r[7:0], fb_short};
            end
            else
            begin
                prn_nxt = {prn_r[21:0], fb_long};
            end
        end
        else
        begin
            prn_nxt = prn_r;
        end
    end

    always_comb
    begin
        corr_nxt    = corr_r;
        dly_cnt_nxt = dly_cnt_r;
        acc_cnt_nxt = acc_cnt_r;
        unique case (corr_r)
            CORR_IDLE:
            begin
                if (start_event)
                begin
                    corr_nxt    = CORR_DELAY;
                    dly_cnt_nxt = trig_delay;
                end
            end
            CORR_DELAY:
            begin
                if (!auto_mode)
                begin
                    corr_nxt = CORR_IDLE;
                end
                else if (dly_cnt_r == 8'h00)
                begin
                    corr_nxt    = CORR_ACC;
                    acc_cnt_nxt = 16'h0000;
                end
                else if (sample_tick_in)
                begin
                    dly_cnt_nxt = dly_cnt_r - 8'h01;
                end
            end
            CORR_ACC:
            begin
                if (!auto_mode || (acc_cnt_r >= acc_target))
                begin
                    corr_nxt = CORR_IDLE;
                end
                else if (sample_tick_in)
                begin
                    acc_cnt_nxt = acc_cnt_r + 16'h0001;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            reg2_r     <= RST_WORD;
            ser_rate_r <= RST_WORD;
            ofs_test_r <= RST_WORD;
            custom_r   <= RST_WORD;
        end
        else
        begin
            if (wr_reg2)
            begin
                reg2_r <= wdata_in & REG2_WMASK;
            end
            if (wr_ser)
            begin
                ser_rate_r <= wdata_in & SER_RATE_WMASK;
            end
            if (wr_ofs)
            begin
                ofs_test_r <= wdata_in & OFS_TEST_WMASK;
            end
            else if (corr_r == CORR_IDLE && start_event && !start_pin)
            begin
                ofs_test_r[START_MAN_BIT] <= 1'b0;                  // manual start self-clears
            end
            if (wr_custom)
            begin
                custom_r <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rdata_r      <= RST_WORD;
            trig_sync_r  <= 3'h0;
            trig_level_r <= 1'b0;
            prn_r        <= PRN_SEED;
            corr_r       <= CORR_IDLE;
            dly_cnt_r    <= 8'h00;
            acc_cnt_r    <= 16'h0000;
        end
        else
        begin
            rdata_r     <= rd_in ? rd_mux : RST_WORD;
            trig_sync_r <= {trig_sync_r[1:0], transmit_trigger_pin_in};
            if (trig_sync_r[1] == trig_sync_r[2])
            begin
                trig_level_r <= trig_sync_r[2];
            end
            prn_r       <= prn_nxt;
            corr_r      <= corr_nxt;
            dly_cnt_r   <= dly_cnt_nxt;
            acc_cnt_r   <= acc_cnt_nxt;
        end
    end

    assign rdata_out                   = rdata_r;
    assign ser_cfg_out.bits_per_sample = bits_sel;
    assign ser_cfg_out.msb_first       = ofs_test_r[MSB_FIRST_BIT];
    assign ser_cfg_out.res_14bit       = (res_code == RES_14);
    assign ser_cfg_out.cfg_error       = ser_bad || res_bad;
    assign dsp_cfg_out.gain_en         = ser_rate_r[GAIN_EN_BIT];
    assign dsp_cfg_out.offset_en       = ser_rate_r[OFS_EN_BIT];
    assign dsp_cfg_out.auto_mode       = auto_mode;
    assign dsp_cfg_out.acc_len         = acc_len;
    assign dsp_cfg_out.trig_delay      = trig_delay;
    assign pat_cfg_out.per_lane        = ofs_test_r[LANE_SEL_BIT];
    assign pat_cfg_out.global_mode     = pat_mode;
    assign pat_cfg_out.custom_active   = (pat_mode == PAT_CUSTOM);
    assign pat_cfg_out.custom_word     = custom_r;
    assign corr_start_out              = (corr_r == CORR_DELAY) && (dly_cnt_r == 8'h00);
    assign corr_busy_out               = (corr_r != CORR_IDLE);
    assign prn_bit_out                 = prn_short ? prn_r[8] : prn_r[22];
    assign prn_state_out               = prn_r;

    // checks
    sequence s_manual_start;
        auto_mode && !start_pin && start_man && corr_r == CORR_IDLE;
    endsequence
    sequence s_pin_start;
        auto_mode && start_pin && trig_rise && corr_r == CORR_IDLE;
    endsequence
    sequence s_delay_tick;
        auto_mode && corr_r == CORR_DELAY && dly_cnt_r != 8'h00 && sample_tick_in;
    endsequence
    sequence s_delay_expired;
        auto_mode && corr_r == CORR_DELAY && dly_cnt_r == 8'h00;
    endsequence
    sequence s_acc_full;
        corr_r == CORR_ACC && acc_cnt_r >= acc_target;
    endsequence

    a_gain_follows_write: assert property (
        wr_ser |=> dsp_cfg_out.gain_en == $past(wdata_in[12]))
        else $error("gain enable not taken from write");
    a_offset_follows_write: assert property (
        wr_ser |=> dsp_cfg_out.offset_en == $past(wdata_in[8]))
        else $error("offset enable not taken from write");
    a_ser_rate_map: assert property (
        (ser_code == 3'h4) |-> ser_cfg_out.bits_per_sample == 5'h10)
        else $error("16x code gives wrong width");
    a_ser_14x_map: assert property (
        (ser_code == 3'h1) |-> ser_cfg_out.bits_per_sample == 5'h0e)
        else $error("14x code gives wrong width");
    a_ser_unused_flag: assert property (
        (ser_code[1] || (ser_code[2] && ser_code[0])) |-> ser_cfg_out.cfg_error)
        else $error("unused serial code not flagged");
    a_delay_split: assert property (
        (wr_ser && !wr_reg2) |=> dsp_cfg_out.trig_delay[7:6] == $past(wdata_in[10:9]))
        else $error("delay high bits wrong");
    a_delay_load: assert property (
        s_pin_start |=> corr_r == CORR_DELAY && dly_cnt_r == $past(trig_delay))
        else $error("delay not loaded on start");
    a_delay_step: assert property (
        s_delay_tick |=> dly_cnt_r == $past(dly_cnt_r) - 8'h01)
        else $error("delay not counted down by a sample");
    a_delay_hold: assert property (
        (auto_mode && corr_r == CORR_DELAY && !sample_tick_in) |=> $stable(dly_cnt_r))
        else $error("delay moved without a sample");
    a_delay_to_acc: assert property (
        s_delay_expired |=> corr_r == CORR_ACC && acc_cnt_r == 16'h0000)
        else $error("accumulation not entered after delay");
    a_start_one_cycle: assert property (
        corr_start_out |=> !corr_start_out)
        else $error("correction start flag longer than a cycle");
    a_auto_mode_bit: assert property (
        wr_ofs |=> dsp_cfg_out.auto_mode == $past(wdata_in[15]))
        else $error("auto mode not taken");
    a_auto_off_stops: assert property (
        (!auto_mode && corr_busy_out) |=> !corr_busy_out)
        else $error("correction kept running after auto mode cleared");
    a_manual_start: assert property (
        s_manual_start |=> corr_busy_out)
        else $error("manual start ignored");
    a_manual_clears: assert property (
        s_manual_start |=> !start_man || $past(wr_ofs))
        else $error("manual start not cleared");
    a_pin_ignored_manual: assert property (
        (corr_r == CORR_IDLE && !start_man) |=> corr_r == CORR_IDLE || $past(start_pin))
        else $error("correction started without its source");
    a_acc_step: assert property (
        (auto_mode && corr_r == CORR_ACC && acc_cnt_r < acc_target && sample_tick_in)
            |=> acc_cnt_r == $past(acc_cnt_r) + 16'h0001)
        else $error("accumulation not counted");
    a_acc_finish: assert property (
        s_acc_full |=> !corr_busy_out)
        else $error("accumulation overran its length");
    a_prn_hold: assert property (
        prn_hold |=> prn_r == 23'h7fffff)
        else $error("generator not held");
    a_prn_disabled: assert property (
        (!prn_hold && !prn_en) |=> $stable(prn_r))
        else $error("generator ran while disabled");
    a_prn_short_len: assert property (
        (prn_short && !prn_hold && prn_en) |=> prn_r[22:9] == 14'h0000)
        else $error("short generator wider than 9 bits");
    a_custom_word: assert property (
        wr_custom |=> pat_cfg_out.custom_word == $past(wdata_in))
        else $error("custom word not stored");
    a_custom_select: assert property (
        (pat_mode == 3'h3) |-> pat_cfg_out.custom_active)
        else $error("custom pattern not selected");
    a_global_mode: assert property (
        wr_reg2 |=> pat_cfg_out.global_mode == $past(wdata_in[9:7]))
        else $error("pattern mode not taken");
    a_msb_first_bit: assert property (
        wr_ofs |=> ser_cfg_out.msb_first == $past(wdata_in[4]))
        else $error("bit order not taken");
    a_lane_select: assert property (
        wr_ofs |=> pat_cfg_out.per_lane == $past(wdata_in[8]))
        else $error("lane select not taken");
    a_res_map: assert property (
        wr_ofs |=> ser_cfg_out.res_14bit == ($past(wdata_in[1:0]) == 2'h1))
        else $error("resolution decode wrong");
    a_res_unused_flag: assert property (
        res_code[1] |-> ser_cfg_out.cfg_error)
        else $error("unused resolution code not flagged");
endmodule : adc_output_config_regs
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the adc output config register bank
// assumes the bank's one-cycle read port, 25 MHz clock and package constants
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adc_cfg_pkg::*;
    logic        clk_sys_in              = 1'h0;
    logic        arst_n_in               = 1'h0;
    logic [3:0]  addr_in                 = 4'h0;
    logic [15:0] wdata_in                = 16'h0000;
    logic        wr_in                   = 1'h0;
    logic        rd_in                   = 1'h0;
    logic        transmit_trigger_pin_in = 1'h0;
    logic        sample_tick_in          = 1'h0;
    logic [15:0] rdata_out;
    ser_cfg_t    ser_cfg;
    dsp_cfg_t    dsp_cfg;
    pat_cfg_t    pat_cfg;
    logic        corr_start_out;
    logic        corr_busy_out;
    logic        prn_bit_out;
    logic [22:0] prn_state_out;
    logic [15:0] exp_q[$];
    logic        rd_pend                 = 1'h0;
    logic        started                 = 1'h0;
    logic [1:0]  tick_div                = 2'h0;
    logic [31:0] rng                     = 32'h13;
    int          bad_count               = 0;
    int          checks                  = 0;
    int          dly_n                   = 0;
    int          acc_n                   = 0;

    always #20 clk_sys_in = ~clk_sys_in;

    adc_output_config_regs adc_output_config_regs_inst
    (
        .clk_sys_in              (clk_sys_in),
        .arst_n_in               (arst_n_in),
        .addr_in                 (addr_in),
        .wdata_in                (wdata_in),
        .wr_in                   (wr_in),
        .rd_in                   (rd_in),
        .rdata_out               (rdata_out),
        .transmit_trigger_pin_in (transmit_trigger_pin_in),
        .sample_tick_in          (sample_tick_in),
        .ser_cfg_out             (ser_cfg),
        .dsp_cfg_out             (dsp_cfg),
        .pat_cfg_out             (pat_cfg),
        .corr_start_out          (corr_start_out),
        .corr_busy_out           (corr_busy_out),
        .prn_bit_out             (prn_bit_out),
        .prn_state_out           (prn_state_out)
    );

    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xorshift

    task automatic check(input logic [22:0] seen, input logic [22:0] expv);
        checks++;
        if (seen !== expv)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    // one write or one read; a read notes its expected word
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        if (w)
            wr_in <= 1'h1;
        else
        begin
            rd_in <= 1'h1;
            exp_q.push_back(d);
        end
        @(posedge clk_sys_in);
        wr_in <= 1'h0;
        rd_in <= 1'h0;
    endtask : bus

    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (corr_busy_out !== v && n < lim)
        begin
            @(posedge clk_sys_in);
            n++;
        end
        #1;
    endtask : wait_busy

    task automatic pulse_trigger();
        @(posedge clk_sys_in);
        transmit_trigger_pin_in <= 1'h1;
        repeat (3) @(posedge clk_sys_in);
        transmit_trigger_pin_in <= 1'h0;
    endtask : pulse_trigger

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // read data monitor, sample pacing and correction tick counting
    always @(posedge clk_sys_in)
    begin
        rd_pend        <= rd_in;
        tick_div       <= tick_div + 2'h1;
        sample_tick_in <= (tick_div == 2'h3);
        if (rd_pend)
            check(rdata_out, exp_q.pop_front());
        if (!corr_busy_out)
            started <= 1'h0;
        else if (corr_start_out)
            started <= 1'h1;
        else if (sample_tick_in && started)
            acc_n++;
        else if (sample_tick_in)
            dly_n++;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        tally_and_finish();
    end

    initial
    begin : main
        logic [31:0] s;
        logic [15:0] r2, r3, r4, r5;
        logic [2:0]  sc;
        logic [22:0] p;
        int          i, d0, a0;
        repeat (12) @(posedge clk_sys_in);
        arst_n_in <= 1'h1;
        for (i = 2; i < 7; i++)
            bus(1'h0, i[3:0], 16'h0000);
        bus(1'h1, 4'h6, 16'hffff);
        bus(1'h0, 4'h6, 16'h0000);
        $display("done: reset values and unmapped index");
        for (i = 0; i < 8; i++)
        begin
            s  = xorshift();
            sc = (i % 3 == 0) ? SER_12X : (i % 3 == 1) ? SER_14X : SER_16X;
            r2 = {6'h00, i[2:0], 1'h0, s[5:0]};
            r3 = {sc, s[12], 1'h0, s[10:9], s[8], 8'h00};
            r4 = {1'h0, s[14], 1'h0, s[12:4], 3'h0, s[0]};
            r5 = s[31:16];
            bus(1'h1, 4'h2, r2);
            bus(1'h1, 4'h3, r3);
            bus(1'h1, 4'h4, r4);
            bus(1'h1, 4'h5, r5);
            #1;
            check(ser_cfg.bits_per_sample,
                  (sc == SER_12X) ? BITS_12 : (sc == SER_14X) ? BITS_14 : BITS_16);
            check(ser_cfg.msb_first, r4[4]);
            check(ser_cfg.res_14bit, r4[0]);
            check(ser_cfg.cfg_error, 1'h0);
            check(dsp_cfg.gain_en, r3[12]);
            check(dsp_cfg.offset_en, r3[8]);
            check(dsp_cfg.trig_delay, {r3[10:9], r2[5:0]});
            check(dsp_cfg.acc_len, r4[12:9]);
            check(pat_cfg.per_lane, r4[8]);
            check(pat_cfg.global_mode, r2[9:7]);
            check(pat_cfg.custom_active, r2[9:7] == PAT_CUSTOM);
            check(pat_cfg.custom_word, r5);
            check(prn_bit_out, r4[6] ? prn_state_out[8] : prn_state_out[22]);
            if (r4[7])
                check(prn_state_out, PRN_SEED);
            bus(1'h0, 4'h2, r2);
            bus(1'h0, 4'h3, r3);
            bus(1'h0, 4'h4, r4);
            bus(1'h0, 4'h5, r5);
        end
        $display("done: field decode and read back");
        bus(1'h1, 4'h4, 16'h00a0);
        @(posedge clk_sys_in);
        #1;
        check(prn_state_out, PRN_SEED);
        bus(1'h1, 4'h4, 16'h0020);
        repeat (4) @(posedge clk_sys_in);
        #1;
        check(prn_state_out === PRN_SEED, 1'h0);
        bus(1'h1, 4'h4, 16'h0000);
        #1;
        p = prn_state_out;
        repeat (4) @(posedge clk_sys_in);
        #1;
        check(prn_state_out, p);
        $display("done: pseudo-random control");
        bus(1'h1, 4'h2, 16'h0002);
        bus(1'h1, 4'h3, 16'h0000);
        bus(1'h1, 4'h4, 16'h4000);
        pulse_trigger();
        repeat (10) @(posedge clk_sys_in);
        #1;
        check(corr_busy_out, 1'h0);
        d0 = dly_n;
        a0 = acc_n;
        bus(1'h1, 4'h4, 16'ha000);
        wait_busy(1'h1, 10);
        check(corr_busy_out, 1'h1);
        check(dsp_cfg.auto_mode, 1'h1);
        wait_busy(1'h0, 60);
        check(corr_busy_out, 1'h0);
        check(dly_n - d0, 23'h2);
        check(acc_n - a0, 23'h1);
        bus(1'h0, 4'h4, 16'h8000);
        a0 = acc_n;
        bus(1'h1, 4'h4, 16'hc200);
        repeat (10) @(posedge clk_sys_in);
        #1;
        check(corr_busy_out, 1'h0);
        pulse_trigger();
        wait_busy(1'h1, 10);
        check(corr_busy_out, 1'h1);
        wait_busy(1'h0, 80);
        check(acc_n - a0, 23'h2);
        $display("done: offset correction start");
        repeat (3) @(posedge clk_sys_in);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
